/* File: src/host_pin_pkg.sv */
// constants, strap levels and serial clock timing for the host pin control block
// What this block does
// RULE1 - A low level on the read strobe pin, not tied to any host clock, starts a read.
// RULE2 - A low level on the write strobe pin, not tied to any host clock, starts a write.
// RULE3 - The ready pin is held low to stretch a host access until the core has finished it.
// RULE4 - Strobes count only while the address qualifier pin is low and are ignored while high.
// RULE5 - The prom select output is asserted for the whole of each serial prom access.
// RULE6 - The prom interface works only if its enable strap was high, and is off when it was low.
// RULE7 - The prom serial clock period is 4us at the 25 MHz speed code and 800ns at 125 MHz.
// RULE8 - The level on the serial clock pin at reset picks big- or little-endian host mode.
// RULE9 - The level on the serial data-in pin at reset picks 16-bit or 8-bit host bus width.
// RULE10 - Without a prom the board pulls data-in low for 8-bit or high for 16-bit bus mode.
// RULE11 - Command bits go out on the serial out pin and prom data is sampled on serial in.
// RULE12 - A low power-down pin releases every driven pin; high or floating means normal work.
// RULE13 - Straps are sampled once after reset release and then held until the next reset.
package host_pin_pkg;

  // clock and serial clock timing
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned SK_PERIOD_SLOW_NS = 4000;
  localparam int unsigned SK_PERIOD_FAST_NS = 800;
  localparam int unsigned HALF_W            = 8;
  localparam logic [HALF_W-1:0] SK_HALF_SLOW =
    HALF_W'(SK_PERIOD_SLOW_NS / (2 * CLK_PERIOD_NS));
  localparam logic [HALF_W-1:0] SK_HALF_FAST =
    HALF_W'(SK_PERIOD_FAST_NS / (2 * CLK_PERIOD_NS));

  // on-chip bus speed codes
  localparam logic [1:0] SPEED_25MHZ  = 2'h3;
  localparam logic [1:0] SPEED_125MHZ = 2'h0;

  // strap capture
  localparam logic [1:0] STRAP_SETTLE    = 2'h2;
  localparam logic       BIG_ENDIAN_LVL  = 1'h1;
  localparam logic       BUS16_LVL       = 1'h1;

  // serial prom access defaults
  localparam int unsigned CMD_BITS_DEF  = 11;
  localparam int unsigned DATA_BITS_DEF = 16;

  typedef enum logic [1:0] {
    PROM_IDLE = 2'b00,
    PROM_LOW  = 2'b01,
    PROM_HIGH = 2'b10,
    PROM_END  = 2'b11
  } prom_state_e;

endpackage

/* File: src/host_pin_ctrl.sv */
// host strobe, serial prom and strap pin control
`timescale 1ns/1ps
module host_pin_ctrl #(
  parameter int unsigned CMD_BITS  = host_pin_pkg::CMD_BITS_DEF,
  parameter int unsigned DATA_BITS = host_pin_pkg::DATA_BITS_DEF
) (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 srst_i,
  // host bus pins
  input  wire logic                 host_read_strobe_n_i,
  input  wire logic                 host_write_strobe_n_i,
  input  wire logic                 addr_qualifier_n_i,
  output logic                      async_cycle_ready_o,
  output logic                      async_cycle_ready_oe_o,
  // power-down pin
  input  wire logic                 chip_powerdown_n_i,
  // serial prom pins
  input  wire logic                 cfg_prom_enable_strap_i,
  input  wire logic                 cfg_prom_serial_in_i,
  input  wire logic                 cfg_prom_serial_clock_i,
  output logic                      cfg_prom_serial_clock_o,
  output logic                      cfg_prom_serial_clock_oe_o,
  output logic                      cfg_prom_serial_out_o,
  output logic                      cfg_prom_serial_out_oe_o,
  output logic                      cfg_prom_select_o,
  output logic                      cfg_prom_select_oe_o,
  // core side, host access
  input  wire logic                 access_done_i,
  output logic                      host_read_o,
  output logic                      host_write_o,
  // core side, prom access
  input  wire logic [1:0]           onchip_bus_speed_ctrl_i,
  input  wire logic                 prom_start_i,
  input  wire logic [CMD_BITS-1:0]  prom_cmd_i,
  output logic                      prom_busy_o,
  output logic                      prom_done_o,
  output logic [DATA_BITS-1:0]      prom_data_o,
  // status
  output logic                      big_endian_o,
  output logic                      bus16_o,
  output logic                      prom_enabled_o,
  output logic                      powered_down_o
);

  localparam int unsigned TOT_BITS = CMD_BITS + DATA_BITS;
  localparam int unsigned CNT_W    = $clog2(TOT_BITS + 1);
  localparam int unsigned HW       = host_pin_pkg::HALF_W;

  typedef struct packed {
    // pin synchronisers, stage 1 feeds only stage 2
    logic                   rd_s1;
    logic                   rd_s2;
    logic                   rd_d;
    logic                   wr_s1;
    logic                   wr_s2;
    logic                   wr_d;
    logic                   aen_s1;
    logic                   aen_s2;
    logic                   pd_s1;
    logic                   pd_s2;
    logic                   en_s1;
    logic                   en_s2;
    logic                   sin_s1;
    logic                   sin_s2;
    logic                   sk_s1;
    logic                   sk_s2;
    // straps
    logic [1:0]             stp_cnt;
    logic                   strap_done;
    logic                   big_endian;
    logic                   bus16;
    logic                   prom_en;
    // host access
    logic                   pd;
    logic                   waiting;
    logic                   host_read;
    logic                   host_write;
    logic                   rdy_lvl;
    logic                   rdy_oe;
    // prom engine
    host_pin_pkg::prom_state_e st;
    logic [HW-1:0]          half_len;
    logic [HW-1:0]          phase;
    logic [CNT_W-1:0]       bit_cnt;
    logic [TOT_BITS-1:0]    shreg;
    logic                   sk;
    logic                   dout;
    logic                   sel;
    logic                   prom_oe;
    logic                   busy;
    logic                   done;
    logic [DATA_BITS-1:0]   data;
  } state_s;

  state_s s;
  state_s next_s;

  logic read_edge;
  logic write_edge;

  // strobes are asynchronous, so edges are taken only after two flops
  assign read_edge  = s.rd_d & ~s.rd_s2 & ~s.aen_s2; // [RULE1] [RULE4]
  assign write_edge = s.wr_d & ~s.wr_s2 & ~s.aen_s2; // [RULE2] [RULE4]

  always_comb begin
    next_s = s;
    next_s.rd_s1  = host_read_strobe_n_i;
    next_s.rd_s2  = s.rd_s1;
    next_s.rd_d   = s.rd_s2;
    next_s.wr_s1  = host_write_strobe_n_i;
    next_s.wr_s2  = s.wr_s1;
    next_s.wr_d   = s.wr_s2;
    next_s.aen_s1 = addr_qualifier_n_i;
    next_s.aen_s2 = s.aen_s1;
    next_s.pd_s1  = chip_powerdown_n_i;
    next_s.pd_s2  = s.pd_s1;
    next_s.en_s1  = cfg_prom_enable_strap_i;
    next_s.en_s2  = s.en_s1;
    next_s.sin_s1 = cfg_prom_serial_in_i;
    next_s.sin_s2 = s.sin_s1;
    next_s.sk_s1  = cfg_prom_serial_clock_i;
    next_s.sk_s2  = s.sk_s1;
    // synchroniser still empty just after reset, so no false power-down
    next_s.pd     = ~s.pd_s2 & (s.strap_done |
                    (s.stp_cnt == host_pin_pkg::STRAP_SETTLE)); // [RULE12]
    next_s.host_read  = 1'h0;
    next_s.host_write = 1'h0;
    next_s.done       = 1'h0;

    // wait for the synchronisers to fill before taking straps
    if (!s.strap_done) begin
      if (s.stp_cnt == host_pin_pkg::STRAP_SETTLE) begin
        next_s.big_endian = (s.sk_s2 == host_pin_pkg::BIG_ENDIAN_LVL); // [RULE8] [RULE13]
        next_s.bus16      = (s.sin_s2 == host_pin_pkg::BUS16_LVL); // [RULE9] [RULE10] [RULE13]
        next_s.prom_en    = s.en_s2; // [RULE6]
        next_s.strap_done = 1'h1;
      end else begin
        next_s.stp_cnt = s.stp_cnt + 2'h1;
      end
    end

    // host access: read wins if both strobes fall together
    if (s.waiting && (access_done_i || (s.rd_s2 && s.wr_s2))) begin
      next_s.waiting = 1'h0; // [RULE3]
    end
    if (!next_s.pd && s.strap_done && !s.waiting) begin
      if (read_edge) begin
        next_s.host_read = 1'h1; // [RULE1]
        next_s.waiting   = 1'h1; // [RULE3]
      end else if (write_edge) begin
        next_s.host_write = 1'h1; // [RULE2]
        next_s.waiting    = 1'h1; // [RULE3]
      end
    end
    if (next_s.pd) begin
      next_s.waiting = 1'h0;
    end
    // open-drain ready: pulled low only while an access is pending
    next_s.rdy_lvl = ~next_s.waiting;
    next_s.rdy_oe  = next_s.waiting; // [RULE3]

    // serial prom engine
    unique case (s.st)
      host_pin_pkg::PROM_IDLE: begin
        next_s.sk   = 1'h0;
        next_s.sel  = 1'h0;
        next_s.dout = 1'h0;
        if (prom_start_i && s.prom_en && s.strap_done && !next_s.pd) begin // [RULE6]
          next_s.sel     = 1'h1; // [RULE5]
          next_s.shreg   = {prom_cmd_i, {DATA_BITS{1'b0}}};
          next_s.dout    = prom_cmd_i[CMD_BITS-1]; // [RULE11]
          next_s.bit_cnt = '0;
          next_s.phase   = '0;
          // unknown speed codes fall back to the slow clock, the safe side
          next_s.half_len = (onchip_bus_speed_ctrl_i == host_pin_pkg::SPEED_125MHZ) ?
                            host_pin_pkg::SK_HALF_FAST : host_pin_pkg::SK_HALF_SLOW; // [RULE7]
          next_s.st = host_pin_pkg::PROM_LOW;
        end
      end
      host_pin_pkg::PROM_LOW: begin
        if (s.phase == s.half_len - HW'(1)) begin
          next_s.phase = '0;
          next_s.sk    = 1'h1; // [RULE7]
          next_s.st    = host_pin_pkg::PROM_HIGH;
        end else begin
          next_s.phase = s.phase + HW'(1);
        end
      end
      host_pin_pkg::PROM_HIGH: begin
        if (s.phase == s.half_len - HW'(1)) begin
          next_s.phase = '0;
          next_s.sk    = 1'h0; // [RULE7]
          next_s.shreg = {s.shreg[TOT_BITS-2:0], s.sin_s2}; // [RULE11]
          next_s.dout  = s.shreg[TOT_BITS-2]; // [RULE11]
          if (s.bit_cnt == CNT_W'(TOT_BITS - 1)) begin
            next_s.st = host_pin_pkg::PROM_END;
          end else begin
            next_s.bit_cnt = s.bit_cnt + CNT_W'(1);
            next_s.st      = host_pin_pkg::PROM_LOW;
          end
        end else begin
          next_s.phase = s.phase + HW'(1);
        end
      end
      host_pin_pkg::PROM_END: begin
        next_s.sel  = 1'h0; // [RULE5]
        next_s.dout = 1'h0;
        next_s.data = s.shreg[DATA_BITS-1:0];
        next_s.done = 1'h1;
        next_s.st   = host_pin_pkg::PROM_IDLE;
      end
    endcase

    // power-down aborts any prom access and releases the pins
    if (next_s.pd) begin
      next_s.st   = host_pin_pkg::PROM_IDLE; // [RULE12]
      next_s.sk   = 1'h0;
      next_s.sel  = 1'h0;
      next_s.dout = 1'h0;
    end
    // serial clock pin stays released until its strap level is taken
    next_s.prom_oe = next_s.strap_done & next_s.prom_en & ~next_s.pd; // [RULE6] [RULE12]
    next_s.busy    = (next_s.st != host_pin_pkg::PROM_IDLE);
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign async_cycle_ready_o        = s.rdy_lvl;
  assign async_cycle_ready_oe_o     = s.rdy_oe;
  assign cfg_prom_serial_clock_o    = s.sk;
  assign cfg_prom_serial_clock_oe_o = s.prom_oe;
  assign cfg_prom_serial_out_o      = s.dout;
  assign cfg_prom_serial_out_oe_o   = s.prom_oe;
  assign cfg_prom_select_o          = s.sel;
  assign cfg_prom_select_oe_o       = s.prom_oe;
  assign host_read_o                = s.host_read;
  assign host_write_o               = s.host_write;
  assign prom_busy_o                = s.busy;
  assign prom_done_o                = s.done;
  assign prom_data_o                = s.data;
  assign big_endian_o               = s.big_endian;
  assign bus16_o                    = s.bus16;
  assign prom_enabled_o             = s.prom_en;
  assign powered_down_o             = s.pd;

  // helper: cycles the serial clock has been high
  logic [HW:0] hi_cnt;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      hi_cnt <= '0;
    end else if (cfg_prom_serial_clock_o) begin
      hi_cnt <= hi_cnt + (HW+1)'(1);
    end else begin
      hi_cnt <= '0;
    end
  end

  sequence seq_read_fall;
    s.rd_d && !s.rd_s2 && !s.aen_s2 && !s.waiting && !next_s.pd && s.strap_done;
  endsequence

  sequence seq_write_fall;
    s.wr_d && !s.wr_s2 && s.rd_s2 && !s.aen_s2 && !s.waiting && !next_s.pd && s.strap_done;
  endsequence

  sequence seq_prom_launch;
    prom_start_i && s.st == host_pin_pkg::PROM_IDLE && s.prom_en && s.strap_done
      && !next_s.pd;
  endsequence

  chk_read_start: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE1]
    seq_read_fall |=> host_read_o && async_cycle_ready_oe_o)
    else $error("read strobe edge did not start a read");

  chk_write_start: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE2]
    seq_write_fall |=> host_write_o && !host_read_o)
    else $error("write strobe edge did not start a write");

  chk_ready_hold: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE3]
    (async_cycle_ready_oe_o && !access_done_i && !(s.rd_s2 && s.wr_s2) && !next_s.pd)
      |=> async_cycle_ready_oe_o && !async_cycle_ready_o)
    else $error("ready released before access finished");

  chk_ready_release: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE3]
    (async_cycle_ready_oe_o && access_done_i) |=> !async_cycle_ready_oe_o ##1 async_cycle_ready_o)
    else $error("ready not released after access done");

  chk_qual_ignore: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE4]
    s.aen_s2 |=> !host_read_o && !host_write_o)
    else $error("access taken while qualifier high");

  chk_select_span: assert property (@(posedge mclk_i) disable iff (srst_i || s.pd) // [RULE5]
    seq_prom_launch |=> cfg_prom_select_o [*8] ##0 prom_busy_o)
    else $error("prom select not held during access");

  chk_prom_off: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE6]
    (s.strap_done && !prom_enabled_o) |=> !cfg_prom_select_o && !cfg_prom_serial_clock_oe_o)
    else $error("prom driven while disabled by strap");

  chk_clock_half: assert property (@(posedge mclk_i) disable iff (srst_i || s.pd) // [RULE7]
    $fell(cfg_prom_serial_clock_o) |-> hi_cnt == {1'b0, s.half_len})
    else $error("serial clock high time wrong");

  chk_clock_rate: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE7]
    (seq_prom_launch ##0 onchip_bus_speed_ctrl_i == host_pin_pkg::SPEED_125MHZ)
      |=> s.half_len == host_pin_pkg::SK_HALF_FAST)
    else $error("fast speed code did not pick 800ns clock");

  chk_data_stable: assert property (@(posedge mclk_i) disable iff (srst_i || s.pd) // [RULE11]
    (cfg_prom_serial_clock_o && $past(cfg_prom_serial_clock_o)) |-> $stable(cfg_prom_serial_out_o))
    else $error("serial out changed while clock high");

  chk_pd_release: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE12]
    powered_down_o |-> !async_cycle_ready_oe_o && !cfg_prom_select_oe_o
      && !cfg_prom_serial_out_oe_o && !cfg_prom_serial_clock_oe_o)
    else $error("pin driven during power-down");

  chk_strap_hold: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE13]
    s.strap_done ##1 s.strap_done |-> $stable(big_endian_o) && $stable(bus16_o))
    else $error("strap value changed after capture");

  chk_strap_take: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE8] [RULE9]
    (!s.strap_done && s.stp_cnt == host_pin_pkg::STRAP_SETTLE)
      |=> big_endian_o == $past(s.sk_s2) && bus16_o == $past(s.sin_s2))
    else $error("strap levels not captured");

endmodule

/* File: testbench/prom_model.sv */
// serial prom and board strap pulls on the far side of the prom pins
`timescale 1ns/1ps
module prom_model #(
  parameter int unsigned          CMD_BITS  = 11,
  parameter int unsigned          DATA_BITS = 16,
  parameter logic [DATA_BITS-1:0] WORD      = 16'h9E4B
) (
  // device pins
  input  wire logic                select_i,
  input  wire logic                select_oe_i,
  input  wire logic                sk_i,
  input  wire logic                sk_oe_i,
  input  wire logic                dout_i,
  // board straps
  input  wire logic                endian_pull_i,
  input  wire logic                width_pull_i,
  // resolved pin levels
  output logic                     sk_pin_o,
  output logic                     din_pin_o,
  // observation
  output logic [CMD_BITS-1:0]      cmd_seen_o,
  output int                       bits_o
);
  logic sel;
  logic drive = 1'b0;
  logic dbit  = 1'b0;
  logic [DATA_BITS-1:0] reply;

  initial cmd_seen_o = '0;
  initial bits_o = 0;
  assign sel = select_oe_i && select_i;
  assign reply = WORD ^ DATA_BITS'(cmd_seen_o);
  // released lines fall back to the strap pulls, never the last bit
  assign sk_pin_o = sk_oe_i ? sk_i : endian_pull_i;
  assign din_pin_o = drive ? dbit : width_pull_i;

  always @(posedge sel) bits_o = 0;
  always @(negedge sel) drive = 1'b0;
  always @(posedge sk_pin_o) begin
    if (sel) begin
      if (bits_o < CMD_BITS) begin
        cmd_seen_o = {cmd_seen_o[CMD_BITS-2:0], dout_i};
      end else if (bits_o < CMD_BITS + DATA_BITS) begin
        drive = 1'b1;
        dbit = reply[DATA_BITS-1-(bits_o-CMD_BITS)];
      end
      bits_o++;
    end
  end
endmodule

/* File: testbench/test_host_bus_strap_eeprom_pins.sv */
// self-checking bench for the host strobe, prom and strap pin block
`timescale 1ns/1ps
module test_host_bus_strap_eeprom_pins;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        rd_n = 1'b1;
  logic        wr_n = 1'b1;
  logic        qual_n = 1'b0;
  logic        pwr_n = 1'b1;
  logic        en_strap = 1'b0;
  logic        endian_pull = 1'b0;
  logic        width_pull = 1'b0;
  logic        done = 1'b0;
  logic [1:0]  speed = 2'h0;
  logic        start = 1'b0;
  logic [10:0] cmd = 11'h0;
  logic        rdy, rdy_oe, sk, sk_oe, dout, dout_oe, sel, sel_oe, sk_pin, din_pin;
  logic        rd_p, wr_p, busy, pdone, big_e, b16, pen, pdn;
  logic [15:0] pdata;
  logic [10:0] cmd_seen;
  int          bits;
  int          fail_count = 0;
  int          compares = 0;

  initial forever #4 mclk_i = ~mclk_i;

  host_pin_ctrl host_pin_ctrl_inst (
    .mclk_i(mclk_i), .srst_i(srst_i), .host_read_strobe_n_i(rd_n),
    .host_write_strobe_n_i(wr_n), .addr_qualifier_n_i(qual_n),
    .async_cycle_ready_o(rdy), .async_cycle_ready_oe_o(rdy_oe), .chip_powerdown_n_i(pwr_n),
    .cfg_prom_enable_strap_i(en_strap), .cfg_prom_serial_in_i(din_pin),
    .cfg_prom_serial_clock_i(sk_pin), .cfg_prom_serial_clock_o(sk),
    .cfg_prom_serial_clock_oe_o(sk_oe), .cfg_prom_serial_out_o(dout),
    .cfg_prom_serial_out_oe_o(dout_oe), .cfg_prom_select_o(sel), .cfg_prom_select_oe_o(sel_oe),
    .access_done_i(done), .host_read_o(rd_p), .host_write_o(wr_p),
    .onchip_bus_speed_ctrl_i(speed), .prom_start_i(start), .prom_cmd_i(cmd),
    .prom_busy_o(busy), .prom_done_o(pdone), .prom_data_o(pdata), .big_endian_o(big_e),
    .bus16_o(b16), .prom_enabled_o(pen), .powered_down_o(pdn));

  prom_model prom_model_inst (
    .select_i(sel), .select_oe_i(sel_oe), .sk_i(sk), .sk_oe_i(sk_oe), .dout_i(dout),
    .endian_pull_i(endian_pull), .width_pull_i(width_pull), .sk_pin_o(sk_pin),
    .din_pin_o(din_pin), .cmd_seen_o(cmd_seen), .bits_o(bits));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // straps are taken once after reset and must not follow later pin changes
  task automatic strap_reset(input logic e, input logic w, input logic en);
    @(posedge mclk_i);
    srst_i <= 1'b1;
    endian_pull <= e;
    width_pull <= w;
    en_strap <= en;
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    #1 check({big_e, b16, pen}, {e, w, en}, "strap capture");
    @(posedge mclk_i);
    endian_pull <= ~e;
    width_pull <= ~w;
    en_strap <= ~en;
    repeat (6) @(posedge mclk_i);
    #1 check({big_e, b16, pen}, {e, w, en}, "strap held");
    @(posedge mclk_i);
    endian_pull <= e;
    width_pull <= w;
    en_strap <= en;
  endtask

  task automatic host_cycle(input logic wr, input logic q);
    int n;
    @(posedge mclk_i);
    qual_n <= q;
    if (wr) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk_i);
      #1 n++;
    end while (rd_p !== 1'b1 && wr_p !== 1'b1 && n < 8);
    if (!q) begin
      check(n, 3, "strobe to pulse");
      check({rd_p, wr_p}, {~wr, wr}, "pulse kind");
      check({rdy_oe, rdy}, 2'b10, "ready low");
      repeat (4) @(posedge mclk_i);
      #1 check({rdy_oe, rdy}, 2'b10, "ready held");
      @(posedge mclk_i);
      done <= 1'b1;
      @(posedge mclk_i);
      done <= 1'b0;
      repeat (2) @(posedge mclk_i);
      #1 check(rdy_oe, 1'b0, "ready released");
    end else begin
      check({rd_p, wr_p, rdy_oe}, 3'b000, "unqualified strobe");
    end
    @(posedge mclk_i);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    qual_n <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask

  task automatic prom_run(input logic [1:0] spd, input logic [10:0] c, input int per_ns);
    realtime t0;
    int n;
    @(posedge mclk_i);
    speed <= spd;
    cmd <= c;
    start <= 1'b1;
    @(posedge mclk_i);
    start <= 1'b0;
    #1 check({sel_oe, sel, busy}, 3'b111, "select up");
    @(posedge sk);
    t0 = $realtime;
    @(posedge sk);
    check(32'(int'($realtime - t0)), per_ns, "sk period");
    n = 0;
    while (pdone !== 1'b1 && n < 14000) begin
      @(posedge mclk_i);
      #1 n++;
      if (pdone !== 1'b1 && n < 2600) check(sel, 1'b1, "select steady");
    end
    check({pdone, sel, busy}, 3'b100, "prom done");
    check(cmd_seen, c, "command bits");
    check(pdata, 16'h9E4B ^ {5'h00, c}, "prom data");
    check(bits, 27, "bit count");
  endtask

  task automatic refused_start();
    @(posedge mclk_i);
    start <= 1'b1;
    @(posedge mclk_i);
    start <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1 check({busy, sel_oe}, 2'b00, "start with prom off");
  endtask

  task automatic power_down();
    @(posedge mclk_i);
    pwr_n <= 1'b0;
    repeat (4) @(posedge mclk_i);
    #1 check(pdn, 1'b1, "powered down");
    check({rdy_oe, sk_oe, dout_oe, sel_oe}, 4'h0, "pins released");
    @(posedge mclk_i);
    pwr_n <= 1'b1;
    repeat (4) @(posedge mclk_i);
    #1 check(pdn, 1'b0, "normal operation");
  endtask

  // sized for the slow serial clock pass, the longest scenario
  initial begin
    #(40000 * 8);
    fail_count++;
    results();
  end

  initial begin
    strap_reset(1'b1, 1'b0, 1'b1);
    host_cycle(1'b0, 1'b0);
    host_cycle(1'b1, 1'b0);
    host_cycle(1'b0, 1'b1);
    prom_run(host_pin_pkg::SPEED_125MHZ, 11'h5A3, 800);
    prom_run(host_pin_pkg::SPEED_25MHZ, 11'h1C6, 4000);
    power_down();
    strap_reset(1'b0, 1'b1, 1'b0);
    refused_start();
    results();
  end
endmodule
